// ### pkg/lar_pkg.sv
// Shared types and constants of the long-address move, OR and rotate datapath
package lar_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned MSB    = 7;
  localparam int unsigned LSB    = 0;

  localparam logic [7:0] ACC_RESET   = 8'h00;
  localparam logic       ZERO_RESET  = 1'b0;
  localparam logic       CARRY_RESET = 1'b0;
  localparam logic [7:0] MEM_DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    LAR_LONG_MOVE_TO_ACC          = 3'h0,
    LAR_LONG_MOVE_TO_MEMORY       = 3'h1,
    LAR_LONG_OR_TO_ACC            = 3'h2,
    LAR_LONG_OR_TO_MEMORY         = 3'h3,
    LAR_LONG_ROTATE_LEFT          = 3'h4,
    LAR_LONG_ROTATE_LEFT_TO_ACC   = 3'h5,
    LAR_LONG_ROTATE_LEFT_CARRY    = 3'h6,
    LAR_LONG_ROTATE_LEFT_CARRY_TO_ACC = 3'h7
  } lar_op_t;

  typedef enum logic [0:0] {
    LAR_IDLE = 1'b0,
    LAR_DONE = 1'b1
  } lar_phase_t;

  // One issued instruction with its memory operand
  typedef struct packed {
    logic       valid;
    lar_op_t    op;
    logic [7:0] memData;
  } lar_req_t;

  // Memory write-back port
  typedef struct packed {
    logic       write;
    logic [7:0] data;
  } lar_memwr_t;

  // Combinational result of one operation
  typedef struct packed {
    logic       accWrite;
    logic       memWrite;
    logic       zeroWrite;
    logic       carryWrite;
    logic [7:0] value;
    logic       carryOut;
  } lar_result_t;

endpackage : lar_pkg

// ### src/lar_exec_unit.sv
// Combinational operation unit: computes result and write enables per opcode
`timescale 1ns/10ps
`default_nettype none
module lar_exec_unit
  import lar_pkg::*;
(
  // Operation and operands
  input  wire lar_op_t     op,
  input  wire logic [7:0]  accIn,
  input  wire logic [7:0]  memIn,
  input  wire logic        carryIn,
  // Result
  output var  lar_result_t res
);

  function automatic logic [7:0] rotl8(input logic [7:0] v, input logic fill);
    rotl8 = {v[MSB-1:LSB], fill};
  endfunction : rotl8

  always_comb begin
    res = '0;
    res.carryOut = carryIn;
    case (op)
      LAR_LONG_MOVE_TO_ACC: begin
        res.value    = memIn;
        res.accWrite = 1'b1;
      end
      LAR_LONG_MOVE_TO_MEMORY: begin
        res.value    = accIn;
        res.memWrite = 1'b1;
      end
      LAR_LONG_OR_TO_ACC: begin
        res.value     = accIn | memIn;
        res.accWrite  = 1'b1;
        res.zeroWrite = 1'b1;
      end
      LAR_LONG_OR_TO_MEMORY: begin
        res.value     = accIn | memIn;
        res.memWrite  = 1'b1;
        res.zeroWrite = 1'b1;
      end
      LAR_LONG_ROTATE_LEFT: begin
        res.value    = rotl8(memIn, memIn[MSB]);
        res.memWrite = 1'b1;
      end
      LAR_LONG_ROTATE_LEFT_TO_ACC: begin
        res.value    = rotl8(memIn, memIn[MSB]);
        res.accWrite = 1'b1;
      end
      LAR_LONG_ROTATE_LEFT_CARRY: begin
        res.value      = rotl8(memIn, carryIn);
        res.carryOut   = memIn[MSB];
        res.memWrite   = 1'b1;
        res.carryWrite = 1'b1;
      end
      default: begin
        res.value      = rotl8(memIn, carryIn);
        res.carryOut   = memIn[MSB];
        res.accWrite   = 1'b1;
        res.carryWrite = 1'b1;
      end
    endcase
  end

endmodule : lar_exec_unit
`default_nettype wire

// ### src/lar_alu.sv
// Top of the long-address move, OR and rotate datapath with accumulator and flags
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Move-to-accumulator copies the memory byte into the accumulator and keeps all flags.
// - Move-to-memory writes the accumulator into the memory byte and keeps all flags.
// - OR-to-accumulator puts accumulator OR memory into the accumulator and changes only zero.
// - OR-to-memory writes accumulator OR memory back to memory and changes only zero.
// - Plain left rotate writes the memory byte rotated left, bit 7 into bit 0, and keeps flags.
// - Plain left rotate to accumulator puts that rotation in the accumulator, memory and flags kept.
// - Rotate through carry writes memory shifted left with old carry in bit 0, bit 7 to carry.
// - Rotate through carry to accumulator does the same into the accumulator, memory untouched.
module lar_alu
  import lar_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Instruction issue with memory operand
  input  wire lar_req_t   req,
  // Memory write-back
  output var  lar_memwr_t memWr,
  // Core state
  output var  logic [7:0] acc,
  output var  logic       zeroFlag,
  output var  logic       carryFlag,
  output var  logic       done
);

  // The rotate and flag logic is fixed to a byte
  if (WIDTH != DATA_W) begin : g_width_check
    $error("lar_alu supports only WIDTH = 8");
  end

  typedef struct packed {
    logic [7:0] acc;
    logic       zero;
    logic       carry;
    logic       memWrite;
    logic [7:0] memData;
    lar_phase_t phase;
  } lar_state_t;

  lar_state_t  st_ff;
  lar_state_t  nxt_st;
  lar_result_t res;

  lar_exec_unit u_exec (
    .op      (req.op),
    .accIn   (st_ff.acc),
    .memIn   (req.memData),
    .carryIn (st_ff.carry),
    .res     (res)
  );

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.memWrite = 1'b0;
    nxt_st.phase    = LAR_IDLE;
    if (req.valid) begin
      nxt_st.phase = LAR_DONE;
      if (res.accWrite) begin
        nxt_st.acc = res.value;
      end
      if (res.memWrite) begin
        nxt_st.memWrite = 1'b1;
        nxt_st.memData  = res.value;
      end
      if (res.zeroWrite) begin
        nxt_st.zero = (res.value == 8'h00);
      end
      if (res.carryWrite) begin
        nxt_st.carry = res.carryOut;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_ff.acc      <= ACC_RESET;
      st_ff.zero     <= ZERO_RESET;
      st_ff.carry    <= CARRY_RESET;
      st_ff.memWrite <= 1'b0;
      st_ff.memData  <= MEM_DATA_RESET;
      st_ff.phase    <= LAR_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign acc        = st_ff.acc;
  assign zeroFlag   = st_ff.zero;
  assign carryFlag  = st_ff.carry;
  assign memWr.write = st_ff.memWrite;
  assign memWr.data  = st_ff.memData;
  assign done       = (st_ff.phase == LAR_DONE);

  // Opcodes whose result goes back to the memory byte; the address itself stays outside,
  // so a write pulse always targets the byte that the caller supplied with the issue
  function automatic logic writesMemory(input lar_op_t o);
    writesMemory = (o == LAR_LONG_MOVE_TO_MEMORY) || (o == LAR_LONG_OR_TO_MEMORY)
      || (o == LAR_LONG_ROTATE_LEFT) || (o == LAR_LONG_ROTATE_LEFT_CARRY);
  endfunction : writesMemory

  // Checks: each fires on the cycle after issue, after an idle cycle or after reset
  sequence s_issue(lar_op_t o);
    req.valid && req.op == o;
  endsequence

  a_move_acc_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_issue(LAR_LONG_MOVE_TO_ACC) |=> acc == $past(req.memData) && $stable(zeroFlag) && $stable(carryFlag)
      && !memWr.write)
    else $error("move to accumulator wrong");

  a_move_mem_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_issue(LAR_LONG_MOVE_TO_MEMORY) |=> memWr.write && memWr.data == $past(acc) && $stable(acc)
      && $stable(zeroFlag) && $stable(carryFlag))
    else $error("move to memory wrong");

  a_or_acc_result: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_issue(LAR_LONG_OR_TO_ACC) |=> acc == ($past(acc) | $past(req.memData)) && $stable(carryFlag))
    else $error("OR to accumulator wrong");

  a_or_mem_result: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_issue(LAR_LONG_OR_TO_MEMORY) |=> memWr.write && memWr.data == ($past(acc) | $past(req.memData))
      && $stable(acc) && $stable(carryFlag))
    else $error("OR to memory wrong");

  a_rotl_mem_plain: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_issue(LAR_LONG_ROTATE_LEFT) |=> memWr.write && memWr.data == {$past(req.memData[6:0]), $past(req.memData[7])}
      && $stable(acc) && $stable(zeroFlag) && $stable(carryFlag))
    else $error("plain rotate to memory wrong");

  a_rotl_acc_plain: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_issue(LAR_LONG_ROTATE_LEFT_TO_ACC) |=> !memWr.write && acc == {$past(req.memData[6:0]), $past(req.memData[7])}
      && $stable(zeroFlag) && $stable(carryFlag))
    else $error("plain rotate to accumulator wrong");

  a_rotc_mem_carry: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_issue(LAR_LONG_ROTATE_LEFT_CARRY) |=> memWr.write && memWr.data == {$past(req.memData[6:0]), $past(carryFlag)}
      && carryFlag == $past(req.memData[7]) && $stable(acc) && $stable(zeroFlag))
    else $error("rotate through carry to memory wrong");

  a_rotc_acc_carry: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_issue(LAR_LONG_ROTATE_LEFT_CARRY_TO_ACC) |=> !memWr.write && acc == {$past(req.memData[6:0]), $past(carryFlag)}
      && carryFlag == $past(req.memData[7]) && $stable(zeroFlag))
    else $error("rotate through carry to accumulator wrong");

  a_zero_flag_or: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_issue(LAR_LONG_OR_TO_ACC) or s_issue(LAR_LONG_OR_TO_MEMORY))
      |=> zeroFlag == (($past(acc) | $past(req.memData)) == 8'h00))
    else $error("zero flag wrong");

  a_idle_no_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !req.valid |=> !memWr.write && !done && $stable(acc))
    else $error("state changed without issue");

  a_reset_state: assert property (@(posedge sys_clk)
    sys_rst |=> acc == ACC_RESET && zeroFlag == ZERO_RESET && carryFlag == CARRY_RESET && !memWr.write && !done)
    else $error("state after reset wrong");

  a_issue_done: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req.valid |=> done)
    else $error("done missing after issue");

  a_zero_only_or: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req.valid && req.op != LAR_LONG_OR_TO_ACC && req.op != LAR_LONG_OR_TO_MEMORY |=> $stable(zeroFlag))
    else $error("zero flag touched by an op that keeps it");

  a_carry_only_rotc: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req.valid && req.op != LAR_LONG_ROTATE_LEFT_CARRY && req.op != LAR_LONG_ROTATE_LEFT_CARRY_TO_ACC
      |=> $stable(carryFlag))
    else $error("carry flag touched by an op that keeps it");

  a_mem_kept_acc: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req.valid && !writesMemory(req.op) |=> !memWr.write && $stable(memWr.data))
    else $error("memory written by an accumulator op");

  a_mem_write_issue: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req.valid && writesMemory(req.op) |=> memWr.write && done)
    else $error("memory write missing");

  // Multi-step checks: a result of one op must be what the next op consumes,
  // which catches a carry or accumulator that is forwarded one cycle late
  sequence s_rotc_mem_then_acc;
    s_issue(LAR_LONG_ROTATE_LEFT_CARRY) ##1 s_issue(LAR_LONG_ROTATE_LEFT_CARRY_TO_ACC);
  endsequence

  sequence s_rotc_acc_then_mem;
    s_issue(LAR_LONG_ROTATE_LEFT_CARRY_TO_ACC) ##1 s_issue(LAR_LONG_ROTATE_LEFT_CARRY);
  endsequence

  sequence s_or_then_move;
    s_issue(LAR_LONG_OR_TO_ACC) ##1 s_issue(LAR_LONG_MOVE_TO_MEMORY);
  endsequence

  a_carry_chain_acc: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_rotc_mem_then_acc |=> acc[0] == $past(req.memData[7], 2))
    else $error("carry chain into accumulator wrong");

  a_carry_chain_mem: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_rotc_acc_then_mem |=> memWr.data[0] == $past(req.memData[7], 2))
    else $error("carry chain into memory wrong");

  a_or_then_move: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_or_then_move |=> memWr.write && memWr.data == ($past(acc, 2) | $past(req.memData, 2)))
    else $error("OR result not moved to memory");

endmodule : lar_alu
`default_nettype wire

// ### tb/lar_alu_tb.sv
// Self-checking bench of the long-address move, OR and rotate datapath
`timescale 1ns/10ps
`default_nettype none
module lar_alu_tb;
  import lar_pkg::*;

  logic       sys_clk;
  logic       sys_rst;
  lar_req_t   req;
  lar_memwr_t memWr;
  logic [7:0] acc;
  logic       zeroFlag;
  logic       carryFlag;
  logic       done;
  int         n_fail;
  int         comparisons;
  int         seed;
  // Reference state kept by the bench
  logic [7:0] mAcc;
  logic [7:0] mWd;
  logic [7:0] res;
  logic       mZ;
  logic       mC;
  logic       mWr;
  logic       mDone;

  lar_alu #(.WIDTH(8)) dut (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .req       (req),
    .memWr     (memWr),
    .acc       (acc),
    .zeroFlag  (zeroFlag),
    .carryFlag (carryFlag),
    .done      (done)
  );

  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic check_all;
    chk("acc", acc, mAcc);
    chk("zeroFlag", {7'h00, zeroFlag}, {7'h00, mZ});
    chk("carryFlag", {7'h00, carryFlag}, {7'h00, mC});
    chk("memWr.write", {7'h00, memWr.write}, {7'h00, mWr});
    chk("memWr.data", memWr.data, mWd);
    chk("done", {7'h00, done}, {7'h00, mDone});
  endtask : check_all

  // Drives one cycle at the falling edge, checks the answer one cycle later
  task automatic issue(input logic v, input lar_op_t op, input logic [7:0] m);
    req.valid   = v;
    req.op      = op;
    req.memData = m;
    mWr   = 1'b0;
    mDone = v;
    if (v) begin
      case (op)
        LAR_LONG_MOVE_TO_ACC: mAcc = m;
        LAR_LONG_MOVE_TO_MEMORY: begin mWr = 1'b1; mWd = mAcc; end
        LAR_LONG_OR_TO_ACC: begin mAcc = mAcc | m; mZ = (mAcc == 8'h00); end
        LAR_LONG_OR_TO_MEMORY: begin
          res = mAcc | m; mWr = 1'b1; mWd = res; mZ = (res == 8'h00);
        end
        LAR_LONG_ROTATE_LEFT: begin mWr = 1'b1; mWd = {m[6:0], m[7]}; end
        LAR_LONG_ROTATE_LEFT_TO_ACC: mAcc = {m[6:0], m[7]};
        LAR_LONG_ROTATE_LEFT_CARRY: begin mWr = 1'b1; mWd = {m[6:0], mC}; mC = m[7]; end
        default: begin mAcc = {m[6:0], mC}; mC = m[7]; end
      endcase
    end
    @(negedge sys_clk);
    check_all();
  endtask : issue

  task automatic model_reset;
    mAcc = 8'h00; mWd = 8'h00; mZ = 1'b0; mC = 1'b0; mWr = 1'b0; mDone = 1'b0;
  endtask : model_reset

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  initial begin
    #100000;
    n_fail++;
    final_report();
  end

  initial begin
    n_fail = 0;
    comparisons = 0;
    seed = 15370;
    sys_rst = 1'b1;
    req = '0;
    model_reset();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    check_all();
    // Directed cases: zero set by OR, then held across rotates; carry in both ways
    issue(1'b1, LAR_LONG_MOVE_TO_ACC, 8'h00);
    issue(1'b1, LAR_LONG_OR_TO_ACC, 8'h00);
    issue(1'b1, LAR_LONG_ROTATE_LEFT_CARRY, 8'h80);
    issue(1'b1, LAR_LONG_ROTATE_LEFT_CARRY_TO_ACC, 8'h01);
    issue(1'b1, LAR_LONG_ROTATE_LEFT_CARRY_TO_ACC, 8'h80);
    issue(1'b1, LAR_LONG_ROTATE_LEFT_CARRY, 8'h00);
    issue(1'b1, LAR_LONG_OR_TO_MEMORY, 8'h40);
    issue(1'b1, LAR_LONG_MOVE_TO_MEMORY, 8'h5a);
    issue(1'b1, LAR_LONG_ROTATE_LEFT, 8'h81);
    issue(1'b1, LAR_LONG_ROTATE_LEFT_TO_ACC, 8'h81);
    issue(1'b1, LAR_LONG_OR_TO_ACC, 8'h24);
    issue(1'b1, LAR_LONG_MOVE_TO_MEMORY, 8'h00);
    issue(1'b0, LAR_LONG_MOVE_TO_ACC, 8'hff);
    // Random mix, back to back with idle gaps
    for (int i = 0; i < 400; i++)
      issue(1'($random(seed)), lar_op_t'(3'($random(seed))), 8'($random(seed)));
    // Reset in mid-run swallows a pending request
    sys_rst = 1'b1;
    req.valid = 1'b1;
    @(negedge sys_clk);
    sys_rst = 1'b0;
    model_reset();
    check_all();
    for (int i = 0; i < 40; i++)
      issue(1'b1, lar_op_t'(3'($random(seed))), 8'($random(seed)));
    final_report();
  end
endmodule : lar_alu_tb
`default_nettype wire
